// ---- shared/bus_master_regs.svh ----
// Offsets, field positions and timing counts of the bus master data port
`ifndef BUS_MASTER_REGS_SVH
`define BUS_MASTER_REGS_SVH
// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define OFF_CTRL     8'h00
`define OFF_ADDR     8'h04
`define OFF_WDATA    8'h08
`define OFF_STATUS   8'h0c
`define OFF_RDATA    8'h10
`define OFF_PSW      8'h14
// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define CTRL_GO      0
`define CTRL_TYPE_LO 1
`define CTRL_TYPE_HI 2
`define ST_BUSY      0
`define ST_DONE      1
`define ST_OWNER     2
`define ST_HOLD      3
`define ST_TIMEOUT   4
// ---------------------------------------------------------------------
// Control register window, 18-bit bus address
// ---------------------------------------------------------------------
`define CREG_LO      18'h3fff8
`define CREG_HI      18'h3fffe
// ---------------------------------------------------------------------
// Timing: figures in ns, counts derived at a 20 ns clock
// ---------------------------------------------------------------------
`define CLK_NS       20
`define ADR_DESKEW_NS 150
`define DAT_DESKEW_NS 75
`define SELF_SYNC_NS 50
`define EARLY_T3_NS  30
`define FREE_CLK_NS  90
`define TIMEOUT_NS   10000
`define CYC_UP(ns)   (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_DN(ns)   ((ns) / `CLK_NS)
`define PRE_CNT_W    4
`endif

// ---- shared/bus_master_pkg.sv ----
// Types of the bus master data port
package bus_master_pkg;
  typedef enum logic [1:0] {
    XFER_WORD_READ  = 2'b00,
    XFER_READ_HOLD  = 2'b01,
    XFER_WORD_WRITE = 2'b10,
    XFER_BYTE_WRITE = 2'b11
  } xfer_t;
  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_STROBE, S_DESKEW, S_SYNC, S_DATA, S_REMOVE, S_T1
  } state_t;
endpackage

// ---- logic/bus_master_port.sv ----
// Processor-side master for word and byte transfers on the system bus
`include "bus_master_regs.svh"
module bus_master_port
  import bus_master_pkg::*;
#(
  parameter int TIMEOUT_CYC = `CYC_DN(`TIMEOUT_NS),
  parameter int ADDR_W      = 18,
  parameter int DATA_W      = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite register bus
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Arbitration side
  input  wire logic              nonprocessorTransferRequest,
  input  wire logic              abortPending,
  // System bus pins
  input  wire logic              busBusyIn,
  output logic                   busBusyOut,
  output logic                   busBusyOe,
  output logic [ADDR_W-1:0]      busAddr,
  output logic                   transferTypeHigh,
  output logic                   transferTypeLow,
  output logic                   busLinesOe,
  input  wire logic [DATA_W-1:0] busDataIn,
  output logic [DATA_W-1:0]      busDataOut,
  output logic                   busDataOe,
  output logic                   masterSync,
  input  wire logic              slaveSyncIn,
  output logic                   slaveSyncOut,
  output logic                   slaveSyncOe,
  // Processor side events
  output logic                   clockResume,
  output logic                   abortEntryState,
  output logic                   busError,
  output logic [DATA_W-1:0]      processorStatusWord
);
  localparam int ADR_CYC  = `CYC_UP(`ADR_DESKEW_NS);
  localparam int DAT_CYC  = `CYC_UP(`DAT_DESKEW_NS);
  localparam int SELF_CYC = `CYC_UP(`SELF_SYNC_NS);
  localparam int T3_CYC   = `CYC_UP(`EARLY_T3_NS);
  localparam int FREE_CYC = `CYC_UP(`FREE_CLK_NS);

  if (ADDR_W != 18 || DATA_W != 16 || TIMEOUT_CYC < 1 ||
      TIMEOUT_CYC > 65535) begin : gBadParams
    $error("bus_master_port: unsupported parameters");
  end

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  state_t              state_ff, nxt_state;
  xfer_t               type_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]   wdata_ff, bufferReg_ff, busBuf_ff;
  logic [7:0]          cnt_ff;
  logic                owner_ff, hold_ff, startBus_ff, master_sync_ff;
  logic                timeout_ff, toErr_ff, done_ff, go_ff;
  logic [3:0]          selfCnt_ff;
  logic                selfSync_ff;
  logic [`PRE_CNT_W-1:0] preCnt_ff;
  logic [2:0]          freeDiv_ff;
  logic                timerRun_ff;
  logic [15:0]         timer_ff;
  logic [DATA_W-1:0]   creg_ff [4];
  logic                slave_sync, ctrlHit, isWrite, freePulse, timeoutHit;
  logic                goStart;

  assign slave_sync    = slaveSyncIn | selfSync_ff;
  assign isWrite = type_ff[1];
  assign ctrlHit = (addr_ff >= `CREG_LO) && (addr_ff <= `CREG_HI);
  assign freePulse  = (freeDiv_ff == 3'(FREE_CYC - 1));
  assign timeoutHit = timerRun_ff && (timer_ff == 16'(TIMEOUT_CYC - 1))
                      && !slave_sync;

  // -------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------
  logic wrFire, rdFire, wrOk, rdOk;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wrFire        = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire        = s_axi_arvalid && s_axi_arready;
  assign wrOk = s_axi_awaddr == `OFF_CTRL || s_axi_awaddr == `OFF_ADDR ||
                s_axi_awaddr == `OFF_WDATA || s_axi_awaddr == `OFF_STATUS;
  assign rdOk = s_axi_araddr <= `OFF_PSW && s_axi_araddr[1:0] == 2'h0;
  assign goStart = wrFire && s_axi_awaddr == `OFF_CTRL && s_axi_wstrb[0]
                   && s_axi_wdata[`CTRL_GO] && state_ff == S_IDLE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOk ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `OFF_CTRL:   s_axi_rdata <= {29'h0, type_ff, 1'b0};
        `OFF_ADDR:   s_axi_rdata <= {14'h0, addr_ff};
        `OFF_WDATA:  s_axi_rdata <= {16'h0, wdata_ff};
        `OFF_STATUS: s_axi_rdata <= {27'h0, toErr_ff, hold_ff, owner_ff,
                                     done_ff, state_ff != S_IDLE};
        `OFF_RDATA:  s_axi_rdata <= {16'h0, bufferReg_ff};
        `OFF_PSW:    s_axi_rdata <= {16'h0, creg_ff[3]};
        default:     s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software loads type, address and write data while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      type_ff  <= XFER_WORD_READ;
      addr_ff  <= '0;
      wdata_ff <= '0;
    end else if (wrFire && state_ff == S_IDLE) begin
      case (s_axi_awaddr)
        `OFF_CTRL: if (s_axi_wstrb[0])
          type_ff <= xfer_t'(s_axi_wdata[`CTRL_TYPE_HI:`CTRL_TYPE_LO]);
        // after read-hold only A0 may change
        `OFF_ADDR: if (hold_ff)
          addr_ff[0] <= s_axi_wdata[0];
        else
          addr_ff <= s_axi_wdata[ADDR_W-1:0];
        `OFF_WDATA: wdata_ff <= s_axi_wdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Transfer sequencer
  // -------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:   if (go_ff) nxt_state = hold_ff ? S_STROBE : S_ARB;
      S_ARB:    if (!nonprocessorTransferRequest && !abortPending &&
                    !busBusyIn) nxt_state = S_STROBE;
      S_STROBE: if (cnt_ff == 8'(T3_CYC - 1)) nxt_state = S_DESKEW;
      S_DESKEW: if (cnt_ff == 8'(ADR_CYC - 1) && !slave_sync && startBus_ff &&
                    !timeout_ff) nxt_state = S_SYNC;
      S_SYNC:   if (timeoutHit) nxt_state = S_REMOVE;
        else if (slave_sync) nxt_state = S_DATA;
      S_DATA:   if (cnt_ff == 8'(DAT_CYC - 1)) nxt_state = S_REMOVE;
      // lines held 75 ns after sync drops
      S_REMOVE: if (cnt_ff == 8'(DAT_CYC - 1)) nxt_state = S_T1;
      S_T1:     nxt_state = S_IDLE;
      default:  nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      go_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      go_ff    <= goStart;
    end
  end

  // Shared delay counter; write deskew restarts while slave_sync is high
  always_ff @(posedge clk) begin
    if (!rst_n || nxt_state != state_ff)
      cnt_ff <= 8'h0;
    // write deskew only while slave_sync negated
    else if (state_ff == S_DESKEW && isWrite && slave_sync)
      cnt_ff <= 8'h0;
    else if (cnt_ff != 8'hff)
      cnt_ff <= cnt_ff + 8'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      owner_ff <= 1'b0;
      hold_ff  <= 1'b0;
    end else if (state_ff == S_ARB && nxt_state == S_STROBE) begin
      owner_ff <= 1'b1;
    end else if (state_ff == S_T1) begin
      hold_ff  <= (type_ff == XFER_READ_HOLD) && !timeout_ff;
      owner_ff <= (type_ff == XFER_READ_HOLD) && !timeout_ff;
    end
  end

  // start-bus flag set by strobe, cleared by slave_sync
  always_ff @(posedge clk) begin
    if (!rst_n)
      startBus_ff <= 1'b0;
    else if (state_ff == S_STROBE && nxt_state == S_DESKEW)
      startBus_ff <= 1'b1;
    else if ((master_sync_ff && slave_sync) || state_ff == S_T1)
      startBus_ff <= 1'b0;
  end

  // master_sync set after deskew, dropped at phase 3
  always_ff @(posedge clk) begin
    if (!rst_n)
      master_sync_ff <= 1'b0;
    else
      master_sync_ff <= (nxt_state == S_SYNC) || (nxt_state == S_DATA);
  end

  // self slave_sync for control register window
  always_ff @(posedge clk) begin
    if (!rst_n || !master_sync_ff) begin
      selfCnt_ff  <= 4'h0;
      selfSync_ff <= 1'b0;
    end else if (ctrlHit) begin
      if (selfCnt_ff != 4'(SELF_CYC - 1))
        selfCnt_ff <= selfCnt_ff + 4'h1;
      else
        selfSync_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Timeout
  // -------------------------------------------------------------------
  // free pulses every 5 cycles (100 ns) and 4-bit pre-counter
  always_ff @(posedge clk) begin
    if (!rst_n || freePulse)
      freeDiv_ff <= 3'h0;
    else
      freeDiv_ff <= freeDiv_ff + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !master_sync_ff)
      preCnt_ff <= '0;
    else if (freePulse)
      preCnt_ff <= preCnt_ff + {{(`PRE_CNT_W-1){1'b0}}, 1'b1};
  end

  // timer runs from the carry until slave_sync or expiry
  always_ff @(posedge clk) begin
    if (!rst_n || slave_sync || !master_sync_ff) begin
      timerRun_ff <= 1'b0;
      timer_ff    <= 16'h0;
    end else if (freePulse && &preCnt_ff) begin
      timerRun_ff <= 1'b1;
    end else if (timerRun_ff) begin
      timer_ff    <= timer_ff + 16'h1;
    end
  end

  // timeout flag blocks sync; error bit set wins clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout_ff <= 1'b0;
      toErr_ff   <= 1'b0;
    end else begin
      if (timeoutHit)
        timeout_ff <= 1'b1;
      else if (goStart)
        timeout_ff <= 1'b0;
      if (timeoutHit)
        toErr_ff <= 1'b1;
      else if (wrFire && s_axi_awaddr == `OFF_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`ST_TIMEOUT])
        toErr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clockResume     <= 1'b0;
      abortEntryState <= 1'b0;
      busError        <= 1'b0;
    end else begin
      clockResume     <= state_ff == S_SYNC && (slave_sync || timeoutHit);
      abortEntryState <= timeoutHit;
      busError        <= timeoutHit;
    end
  end

  // -------------------------------------------------------------------
  // Data, control registers, done
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busBuf_ff    <= '0;
      bufferReg_ff <= '0;
      done_ff      <= 1'b0;
      for (int i = 0; i < 4; i++) creg_ff[i] <= '0;
    end else begin
      // read data latched at phase three
      if (state_ff == S_DATA && nxt_state == S_REMOVE && !isWrite)
        busBuf_ff <= ctrlHit ? creg_ff[addr_ff[2:1]] : busDataIn;
      // control registers take the write data register
      if (state_ff == S_DATA && nxt_state == S_REMOVE && isWrite &&
          ctrlHit)
        creg_ff[addr_ff[2:1]] <= wdata_ff;
      // buffer register loaded at phase one
      if (state_ff == S_T1 && !isWrite && !timeout_ff)
        bufferReg_ff <= busBuf_ff;
      if (goStart)
        done_ff <= 1'b0;
      else if (state_ff == S_T1)
        done_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------------
  // drivers gated by the owner flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busAddr          <= '0;
      transferTypeHigh <= 1'b0;
      transferTypeLow  <= 1'b0;
      busDataOut       <= '0;
    end else begin
      busAddr          <= addr_ff;
      transferTypeHigh <= type_ff[1];
      transferTypeLow  <= type_ff[0];
      busDataOut       <= wdata_ff;
    end
  end

  assign busBusyOut          = owner_ff;
  assign busBusyOe           = owner_ff;
  assign busLinesOe          = owner_ff && state_ff != S_T1 &&
                               state_ff != S_ARB;
  assign busDataOe           = busLinesOe && isWrite;
  assign masterSync          = master_sync_ff;
  assign slaveSyncOut        = selfSync_ff;
  assign slaveSyncOe         = selfSync_ff;
  assign processorStatusWord = creg_ff[3];

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sync_needs_owner;
    masterSync |-> busBusyOut && busLinesOe;
  endproperty
  a_sync_needs_owner: assert property (p_sync_needs_owner)
    else $error("master sync without bus ownership");

  property p_deskew;
    $rose(masterSync) |-> $past(state_ff == S_DESKEW, 8);
  endproperty
  a_deskew: assert property (p_deskew)
    else $error("master sync before address deskew");

  property p_write_after_neg;
    $rose(masterSync) && isWrite |-> $past(!slave_sync, 8);
  endproperty
  a_write_after_neg: assert property (p_write_after_neg)
    else $error("write sync too soon after slave sync");

  property p_data_wait;
    $rose(state_ff == S_DATA) |-> masterSync [*4];
  endproperty
  a_data_wait: assert property (p_data_wait)
    else $error("master sync dropped before data deskew");

  property p_remove_wait;
    $fell(masterSync) && !timeout_ff |-> busLinesOe [*4];
  endproperty
  a_remove_wait: assert property (p_remove_wait)
    else $error("lines removed too soon after sync");

  property p_self_sync;
    $rose(masterSync) && ctrlHit |-> ##3 selfSync_ff;
  endproperty
  a_self_sync: assert property (p_self_sync)
    else $error("self slave sync not after 50 ns");

  property p_no_drive_unowned;
    !owner_ff |-> !busLinesOe && !busDataOe && !busBusyOe;
  endproperty
  a_no_drive_unowned: assert property (p_no_drive_unowned)
    else $error("drivers active without owner flag");

  property p_timeout_abort;
    timeoutHit |=> busError && abortEntryState && toErr_ff && !masterSync;
  endproperty
  a_timeout_abort: assert property (p_timeout_abort)
    else $error("timeout did not abort");

  property p_owner_set;
    $rose(owner_ff) |-> $past(!busBusyIn && !abortPending &&
                              !nonprocessorTransferRequest);
  endproperty
  a_owner_set: assert property (p_owner_set)
    else $error("owner flag set with bus not free");
endmodule

// ---- test/bus_slave_model.sv ----
// Slave model answering transfers of the bus master data port
`include "bus_master_regs.svh"
module bus_slave_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Lines from the master
  input  wire logic        masterSync,
  input  wire logic [17:0] addr,
  input  wire logic [1:0]  xferType,
  input  wire logic [15:0] wrData,
  // Behaviour control
  input  wire logic        answerOn,
  input  wire logic [3:0]  delay,
  // Lines back to the master, and last type seen for the testbench
  output logic             sync,
  output logic [15:0]      rdData,
  output logic [1:0]       lastType
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [3:0]  cnt;
  logic [3:0]  idx;
  assign idx = addr[4:1];
  always @(posedge clk) begin
    if (!rst_n) begin
      sync     <= 1'b0;
      cnt      <= 4'h0;
      rdData   <= 16'h5a5a;
      lastType <= 2'b00;
    end else if (!masterSync) begin
      sync <= 1'b0;
      cnt  <= 4'h0;
      // Released data lines must not keep the last value
      if (sync) rdData <= ~rdData;
    end else if (answerOn && addr < `CREG_LO && !sync) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay) begin
        sync     <= 1'b1;
        lastType <= xferType;
        if (xferType == 2'b10) mem[idx] <= wrData;
        else if (xferType == 2'b11 && addr[0])
          mem[idx][15:8] <= wrData[15:8];
        else if (xferType == 2'b11) mem[idx][7:0] <= wrData[7:0];
        else rdData <= mem[idx];
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Testbench of the bus master data port
`include "bus_master_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bus_master_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, delay = 4'h0;
  logic nonprocessorTransferRequest = 1'b0, abortPending = 1'b0;
  logic otherBusy = 1'b0, answerOn = 1'b1, msPrev = 1'b0, selfSync = 1'b0;
  logic resumeSeen = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, busBusyOut, busBusyOe, transferTypeHigh;
  logic transferTypeLow, busLinesOe, busDataOe, masterSync, slaveSyncOut;
  logic slaveSyncOe, clockResume, abortEntryState, busError, peerSync;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, lastType;
  logic [17:0] busAddr;
  logic [15:0] busDataIn, busDataOut, processorStatusWord;
  logic [31:0] v;
  wire busBusyIn = (busBusyOe & busBusyOut) | otherBusy;
  wire slaveSyncIn = peerSync | (slaveSyncOe & slaveSyncOut);
  int miscompares = 0, nChecks = 0, lv = 0, sv = 0, mh = 0, errs = 0;
  int aborts = 0;
  always #10 clk = ~clk;
  bus_master_port #(.TIMEOUT_CYC(20)) DUT (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nonprocessorTransferRequest, .abortPending, .busBusyIn,
    .busBusyOut, .busBusyOe, .busAddr, .transferTypeHigh, .transferTypeLow,
    .busLinesOe, .busDataIn, .busDataOut, .busDataOe, .masterSync,
    .slaveSyncIn, .slaveSyncOut, .slaveSyncOe, .clockResume, .abortEntryState,
    .busError, .processorStatusWord);
  bus_slave_model peer (.clk, .rst_n, .masterSync,
    .addr(busLinesOe ? busAddr : 18'h0),
    .xferType(busLinesOe ? {transferTypeHigh, transferTypeLow} : 2'b00),
    .wrData(busDataOe ? busDataOut : 16'h0),
    .answerOn, .delay, .sync(peerSync), .rdData(busDataIn), .lastType);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    if (!b) miscompares++;
    if (!b) wrap_up();
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic r;
    r = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !r; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    if (!r) miscompares++;
    if (!r) wrap_up();
  endtask
  task automatic go(input xfer_t t, input logic [17:0] a,
                    input logic [15:0] d);
    axw(`OFF_ADDR, {14'h0, a});
    axw(`OFF_WDATA, {16'h0, d});
    axw(`OFF_CTRL, {29'h0, t, 1'b1});
  endtask
  task automatic finish_xfer;
    v = 32'h1;
    for (int n = 0; n < 100 && v[`ST_BUSY]; n++) axr(`OFF_STATUS, v);
    if (v[`ST_BUSY]) miscompares++;
    if (v[`ST_BUSY]) wrap_up();
  endtask
  task automatic xfer(input xfer_t t, input logic [17:0] a,
                      input logic [15:0] d);
    go(t, a, d);
    finish_xfer();
  endtask
  // ----------------------------------------------------------------------
  // Bus line monitor
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    msPrev <= masterSync;
    lv <= busLinesOe ? lv + 1 : 0;
    sv <= (masterSync && slaveSyncIn) ? sv + 1 : 0;
    mh <= masterSync ? mh + 1 : 0;
    if (busError) errs <= errs + 1;
    if (abortEntryState) aborts <= aborts + 1;
    if (slaveSyncOe && slaveSyncOut) selfSync <= 1'b1;
    if (masterSync && !msPrev) resumeSeen <= 1'b0;
    else if (clockResume) resumeSeen <= 1'b1;
    if (masterSync && !msPrev) chk("addr deskew", lv >= 8, 1);
    if (!masterSync && msPrev && sv > 0)
      chk("data deskew", sv >= 4, 1);
    if (!masterSync && msPrev)
      chk("clock resume", resumeSeen || clockResume, 1);
    if (busLinesOe)
      chk("busy with lines", busBusyOe & busBusyOut, 1);
    if (busError)
      chk("timeout span", mh >= 94 && mh <= 110, 1);
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axr(`OFF_STATUS, v);
    chk("status after reset", v, 32'h0);
    chk("lines after reset", {busBusyOe, busLinesOe, masterSync}, 0);
    axw(8'h40, 32'h1);
    chk("unmapped write", resp, 2'b10);
    axr(8'h40, v);
    chk("unmapped read", resp, 2'b10);
    nonprocessorTransferRequest <= 1'b1;
    go(XFER_WORD_WRITE, 18'h00100, 16'h1234);
    repeat (15) @(posedge clk);
    chk("owner while request", busBusyOe, 0);
    nonprocessorTransferRequest <= 1'b0;
    otherBusy <= 1'b1;
    repeat (15) @(posedge clk);
    chk("owner while busy", busBusyOe, 0);
    otherBusy <= 1'b0;
    abortPending <= 1'b1;
    repeat (15) @(posedge clk);
    chk("owner while abort", busBusyOe, 0);
    abortPending <= 1'b0;
    finish_xfer();
    chk("done flag", v[`ST_DONE], 1);
    chk("word write type", lastType, 2'b10);
    delay <= 4'h6;
    xfer(XFER_WORD_READ, 18'h00100, 16'h0);
    axr(`OFF_RDATA, v);
    chk("slow read", v, 32'h1234);
    delay <= 4'h0;
    xfer(XFER_WORD_WRITE, 18'h00102, 16'h5678);
    xfer(XFER_READ_HOLD, 18'h00102, 16'h0);
    axr(`OFF_STATUS, v);
    chk("hold flag", v[`ST_HOLD], 1);
    chk("busy kept", busBusyOe & busBusyOut, 1);
    chk("hold type", lastType, 2'b01);
    xfer(XFER_BYTE_WRITE, 18'h00103, 16'hab00);
    chk("byte type", lastType, 2'b11);
    chk("busy freed", busBusyOe, 0);
    xfer(XFER_WORD_READ, 18'h00102, 16'h0);
    axr(`OFF_RDATA, v);
    chk("odd byte merge", v, 32'hab78);
    xfer(XFER_WORD_WRITE, `CREG_HI, 16'h00f0);
    chk("self sync", selfSync, 1);
    chk("status word port", processorStatusWord, 16'h00f0);
    xfer(XFER_WORD_READ, `CREG_HI, 16'h0);
    axr(`OFF_RDATA, v);
    chk("status word by bus", v, 32'h00f0);
    answerOn <= 1'b0;
    xfer(XFER_WORD_READ, 18'h00104, 16'h0);
    axr(`OFF_STATUS, v);
    chk("timeout bit", v[`ST_TIMEOUT], 1);
    chk("error pulses", {errs[3:0], aborts[3:0]}, 8'h11);
    axr(`OFF_RDATA, v);
    chk("no data on timeout", v, 32'h00f0);
    axw(`OFF_STATUS, 32'h10);
    axr(`OFF_STATUS, v);
    chk("timeout bit cleared", v[`ST_TIMEOUT], 0);
    wrap_up();
  end
endmodule
